// ===== sbc_mcu_ctrl_defines.vh
`ifndef SBC_MCU_CTRL_DEFINES_VH
`define SBC_MCU_CTRL_DEFINES_VH
// Mode codes
`define MODE_RESET 3'h0
`define MODE_NREQ 3'h1
`define MODE_NORMAL 3'h2
`define MODE_STOP 3'h3
`define MODE_SLEEP 3'h4
// Frame
`define FRAME_BITS 4'h8
// Command layout: [7:5] address, [4:0] data
`define CMD_ADDR_MSB 7
`define CMD_ADDR_LSB 5
`define ADDR_MODE 3'h0
`define ADDR_HSIDE 3'h1
`define ADDR_LSIDE 3'h2
`define ADDR_MUX 3'h3
`define ADDR_GAIN 3'h4
`define ADDR_HALL 3'h5
`define ADDR_CYCLIC 3'h6
`define ADDR_STATUS 3'h7
// Mux channels
`define MUX_BATT 3'h0
`define MUX_WAKE1 3'h1
`define MUX_WAKE4 3'h4
`define MUX_TEMP 3'h5
// Reset values
`define RST_MUX 3'h0
`define RST_GAIN 2'h0
// Timing
`define RST_FILT_NS 1000
`define CLK_NS 4
`define RST_FILT_CYC ((`RST_FILT_NS + `CLK_NS - 1) / `CLK_NS)
`define RST_OUT_NS 1000000
`define RST_OUT_CYC (`RST_OUT_NS / `CLK_NS)
`define WDOG_DEF_MS 150
`define WDOG_DEF_CYC (`WDOG_DEF_MS * 1000000 / `CLK_NS)
`define CYC_PERIOD_CYC 2500000
`define CYC_ON_CYC 250
`endif

// ===== sbc_mcu_control_interface.v
`timescale 1ns/1ps
`include "sbc_mcu_ctrl_defines.vh"
module sbc_mcu_control_interface #(
   parameter RST_OUT_CYC = `RST_OUT_CYC,
   parameter WDOG_DEF_CYC = `WDOG_DEF_CYC,
   parameter CYC_PERIOD_CYC = `CYC_PERIOD_CYC
) (
   // Clock and reset
   input wire clk,
   input wire rst,
   // Serial link
   input wire chipSelN,
   input wire serialClk,
   input wire serialIn,
   output reg serialOut,
   output reg serialOutEnN,
   // Reset pin
   input wire resetPinIn,
   output reg resetPinOut,
   output reg resetPinOeN,
   // Interrupt
   output reg irqN,
   // Watchdog strap: 00 grounded, 01 resistor, 10 open
   input wire [1:0] watchdogConfigPin,
   output reg watchdogEnable,
   output reg watchdogDefault,
   // Events from the analog side
   input wire faultEvent,
   input wire resetCondition,
   // Switches
   input wire pwmDriveInput,
   output reg [1:0] highSwitch,
   output reg [1:0] lowSwitch,
   // Wake inputs and analog controls
   input wire [3:0] wakeInput,
   output reg [2:0] analogMuxSel,
   output reg [1:0] currentAmpGain,
   output reg hallSensorSupply,
   output reg [2:0] modeState
);
   // Two-stage synchronisers; only stage 2 is read
   reg [5:0] s1_r;
   reg [5:0] s2_r;
   reg [3:0] w1_r;
   reg [3:0] w2_r;
   reg csPrev_r;
   reg sckPrev_r;
   wire csS = s2_r[0];
   wire sckS = s2_r[1];
   wire mosiS = s2_r[2];
   wire rstPinS = s2_r[3];
   wire pwmS = s2_r[4];
   always @(posedge clk) begin
      if (rst) begin
         // Reset pin reads low here: we pull it during reset
         s1_r <= 6'h13;
         s2_r <= 6'h13;
         w1_r <= 4'h0;
         w2_r <= 4'h0;
      end else begin
         s1_r <= {1'b0, pwmDriveInput, resetPinIn, serialIn, serialClk, chipSelN};
         s2_r <= s1_r;
         w1_r <= wakeInput;
         w2_r <= w1_r;
      end
   end

   wire csFall = csPrev_r & ~csS;
   wire csRise = ~csPrev_r & csS;
   wire sckRise = ~sckPrev_r & sckS & ~csS;
   wire sckFallE = sckPrev_r & ~sckS & ~csS;

   function muxHidesInput;
      input [2:0] sel;
      input [1:0] idx;
      begin
         muxHidesInput = (sel == (`MUX_WAKE1 + {1'b0, idx}));
      end
   endfunction

   reg [7:0] shiftIn_r;
   reg [7:0] shiftOut_r;
   reg [4:0] bitCnt_r;
   reg [1:0] hsCtl_r;
   reg [1:0] lsCtl_r;
   reg hsPwmEn_r;
   reg lsPwmEn_r;
   reg cycEn_r;
   reg cycSel_r;
   reg [3:0] status_r;
   reg [3:0] wakePrev_r;
   reg [3:0] cycSample_r;
   reg [23:0] rstCnt_r;
   reg [31:0] timer_r;
   reg [31:0] cycCnt_r;
   reg [1:0] strap_r;
   reg strapTaken_r;
   reg rstFiltered_r;
   reg [7:0] filtCnt_r;
   reg [2:0] mode_nxt;
   wire [3:0] digMask;
   // Short periods would otherwise leave the switch on for the whole cycle
   localparam CYC_ON = (CYC_PERIOD_CYC > 2 * `CYC_ON_CYC) ? `CYC_ON_CYC : CYC_PERIOD_CYC / 2;
   assign digMask[0] = ~muxHidesInput(analogMuxSel, 2'h0);
   assign digMask[1] = ~muxHidesInput(analogMuxSel, 2'h1);
   assign digMask[2] = ~muxHidesInput(analogMuxSel, 2'h2);
   assign digMask[3] = ~muxHidesInput(analogMuxSel, 2'h3);
   wire [3:0] wakeDig = w2_r & digMask;
   wire frameOk = csRise & (bitCnt_r == {1'b0, `FRAME_BITS});
   wire [2:0] cmdAddr = shiftIn_r[`CMD_ADDR_MSB:`CMD_ADDR_LSB];
   wire normalish = (modeState == `MODE_NORMAL) || (modeState == `MODE_NREQ);
   wire lowPower = (modeState == `MODE_STOP) || (modeState == `MODE_SLEEP);
   wire inCycOn = cycEn_r && (cycCnt_r < CYC_ON);
   wire cycSampleNow = cycEn_r && (cycCnt_r == CYC_ON - 1);
   wire inChange = lowPower && !cycEn_r && (wakeDig != wakePrev_r);
   wire cycChange = lowPower && cycSampleNow && (wakeDig != cycSample_r);
   wire stopCsWake = (modeState == `MODE_STOP) && csRise;
   wire wakeEvt = inChange | cycChange;

   always @(posedge clk) begin
      if (rst) begin
         csPrev_r <= 1'b1;
         sckPrev_r <= 1'b1;
         bitCnt_r <= 5'h0;
         shiftIn_r <= 8'h00;
         shiftOut_r <= 8'h00;
         serialOut <= 1'b0;
         serialOutEnN <= 1'b1;
      end else begin
         csPrev_r <= csS;
         sckPrev_r <= sckS;
         serialOutEnN <= csS;
         if (csFall) begin
            bitCnt_r <= 5'h0;
            shiftOut_r <= {normalish, modeState, wakeDig};
            serialOut <= normalish;
         end else if (sckRise) begin
            shiftIn_r <= {shiftIn_r[6:0], mosiS};
            if (bitCnt_r != 5'h1f) begin
               bitCnt_r <= bitCnt_r + 5'h1;
            end
         end else if (sckFallE) begin
            shiftOut_r <= {shiftOut_r[6:0], 1'b0};
            serialOut <= shiftOut_r[6];
         end
      end
   end

   // Reset pin glitch filter
   always @(posedge clk) begin
      if (rst) begin
         filtCnt_r <= 8'h0;
         rstFiltered_r <= 1'b0;
      end else begin
         if (rstPinS == rstFiltered_r) begin
            filtCnt_r <= 8'h0;
         end else if (filtCnt_r == (`RST_FILT_CYC - 1)) begin
            filtCnt_r <= 8'h0;
            rstFiltered_r <= rstPinS;
         end else begin
            filtCnt_r <= filtCnt_r + 8'h1;
         end
      end
   end

   // Mode sequencing
   always @* begin
      mode_nxt = modeState;
      case (modeState)
         `MODE_RESET: mode_nxt = `MODE_RESET;
         `MODE_NREQ, `MODE_NORMAL: begin
            if (frameOk && cmdAddr == `ADDR_MODE) begin
               case (shiftIn_r[1:0])
                  2'h0: mode_nxt = `MODE_NORMAL;
                  2'h1: mode_nxt = `MODE_STOP;
                  2'h2: mode_nxt = `MODE_SLEEP;
                  default: mode_nxt = modeState;
               endcase
            end
         end
         `MODE_STOP: if (wakeEvt || stopCsWake) mode_nxt = `MODE_NREQ;
         `MODE_SLEEP: if (wakeEvt) mode_nxt = `MODE_RESET;
         default: mode_nxt = `MODE_RESET;
      endcase
   end

   always @(posedge clk) begin
      if (rst) begin
         modeState <= `MODE_RESET;
         rstCnt_r <= 24'h0;
         resetPinOut <= 1'b0;
         resetPinOeN <= 1'b0;
         timer_r <= 32'h0;
         strap_r <= 2'h0;
         strapTaken_r <= 1'b0;
         watchdogEnable <= 1'b0;
         watchdogDefault <= 1'b0;
      end else begin
         // Strap caught after reset release, not under reset
         if (!strapTaken_r) begin
            strap_r <= watchdogConfigPin;
            strapTaken_r <= 1'b1;
         end
         watchdogEnable <= strapTaken_r && (strap_r != 2'h0);
         watchdogDefault <= strapTaken_r && (strap_r == 2'h2);
         // A new condition restarts the pull even after the pin was let go
         if (resetCondition && (modeState != `MODE_RESET || resetPinOeN)) begin
            modeState <= `MODE_RESET;
            rstCnt_r <= 24'h0;
            resetPinOeN <= 1'b0;
         end else if (modeState == `MODE_RESET) begin
            if (rstCnt_r < RST_OUT_CYC[23:0]) begin
               rstCnt_r <= rstCnt_r + 24'h1;
            end else begin
               resetPinOeN <= 1'b1;
            end
            // Level, not edge: a short pull may never get through the filter
            if (resetPinOeN && rstFiltered_r) begin
               modeState <= `MODE_NREQ;
               timer_r <= 32'h0;
            end
         end else if (rstFiltered_r == 1'b0) begin
            // Microcontroller holds the pin: follow it back through reset
            modeState <= `MODE_RESET;
            rstCnt_r <= RST_OUT_CYC[23:0];
         end else begin
            modeState <= mode_nxt;
            if (modeState == `MODE_NREQ && strap_r != 2'h1) begin
               // Grounded strap skips the wait; open strap waits the default period
               if (strap_r == 2'h0 || timer_r >= WDOG_DEF_CYC) modeState <= `MODE_NORMAL;
               timer_r <= timer_r + 32'h1;
            end else begin
               timer_r <= 32'h0;
            end
         end
      end
   end

   // Command registers, committed only on a good frame; hall supply also cleared outside normal and request
   always @(posedge clk) begin
      if (rst) begin
         hsCtl_r <= 2'h0;
         lsCtl_r <= 2'h0;
         hsPwmEn_r <= 1'b0;
         lsPwmEn_r <= 1'b0;
         analogMuxSel <= `RST_MUX;
         currentAmpGain <= `RST_GAIN;
         hallSensorSupply <= 1'b0;
         cycEn_r <= 1'b0;
         cycSel_r <= 1'b0;
      end else begin
         if (frameOk) begin
            case (cmdAddr)
               `ADDR_HSIDE: begin
                  hsCtl_r <= shiftIn_r[1:0];
                  hsPwmEn_r <= shiftIn_r[2];
               end
               `ADDR_LSIDE: begin
                  lsCtl_r <= shiftIn_r[1:0];
                  lsPwmEn_r <= shiftIn_r[2];
               end
               `ADDR_MUX: if (shiftIn_r[2:0] <= `MUX_TEMP) analogMuxSel <= shiftIn_r[2:0];
               `ADDR_GAIN: currentAmpGain <= shiftIn_r[1:0];
               `ADDR_HALL: if (modeState == `MODE_NORMAL) hallSensorSupply <= shiftIn_r[0];
               `ADDR_CYCLIC: begin
                  cycEn_r <= shiftIn_r[0];
                  cycSel_r <= shiftIn_r[1];
               end
               default: cycEn_r <= cycEn_r;
            endcase
         end
         if (!normalish) hallSensorSupply <= 1'b0;
      end
   end

   // Switches, cyclic sense and interrupt
   always @(posedge clk) begin
      if (rst) begin
         highSwitch <= 2'h0;
         lowSwitch <= 2'h0;
         cycCnt_r <= 32'h0;
         cycSample_r <= 4'h0;
         wakePrev_r <= 4'h0;
         status_r <= 4'h0;
         irqN <= 1'b1;
      end else begin
         if (normalish) begin
            highSwitch <= hsPwmEn_r ? (hsCtl_r & {2{pwmS}}) : hsCtl_r;
            lowSwitch <= lsPwmEn_r ? (lsCtl_r & {2{pwmS}}) : lsCtl_r;
         end else if (lowPower && inCycOn) begin
            highSwitch <= cycSel_r ? 2'h2 : 2'h1;
            lowSwitch <= 2'h0;
         end else begin
            highSwitch <= 2'h0;
            lowSwitch <= 2'h0;
         end
         cycCnt_r <= (cycCnt_r >= CYC_PERIOD_CYC - 1) ? 32'h0 : cycCnt_r + 32'h1;
         if (cycSampleNow) cycSample_r <= wakeDig;
         wakePrev_r <= wakeDig;
         // Set wins over clear
         if ((normalish && faultEvent) || (modeState == `MODE_STOP && wakeEvt)) begin
            status_r <= status_r | {normalish & faultEvent, wakeEvt, 2'h0};
         end else if (frameOk && cmdAddr == `ADDR_STATUS) begin
            status_r <= 4'h0;
         end
         irqN <= ~(|status_r);
      end
   end
endmodule

// ===== sbc_mcu_control_interface_props.sv
`timescale 1ns/1ps
`include "sbc_mcu_ctrl_defines.vh"
module sbc_mcu_control_interface_props (
   // Clock and reset
   input wire clk,
   input wire rst,
   // Watched pins
   input wire chipSelN,
   input wire serialOutEnN,
   input wire resetPinOut,
   input wire resetPinOeN,
   input wire irqN,
   input wire [1:0] watchdogConfigPin,
   input wire watchdogEnable,
   input wire watchdogDefault,
   input wire resetCondition,
   input wire [1:0] highSwitch,
   input wire [1:0] lowSwitch,
   input wire hallSensorSupply,
   input wire [2:0] modeState
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   wire normalish = modeState == `MODE_NREQ || modeState == `MODE_NORMAL;
   wire lowPower = modeState == `MODE_STOP || modeState == `MODE_SLEEP;
   // Two synchroniser flops and the enable flop lag the select
   chk_miso_idle: assert property (chipSelN [*4] |-> serialOutEnN)
      else $error("data out driven while deselected");
   chk_reset_state: assert property (disable iff (1'b0) rst |=> !resetPinOeN && irqN)
      else $error("wrong pin levels in reset");
   chk_pin_low: assert property (!resetPinOeN |-> !resetPinOut)
      else $error("reset pin driven high");
   chk_cond_pull: assert property (resetCondition |-> ##[1:4] !resetPinOeN)
      else $error("reset condition not passed to pin");
   chk_release_mode: assert property ($rose(resetPinOeN) |-> ##[1:300] normalish)
      else $error("no normal request after pin release");
   chk_hall_normal: assert property ($rose(hallSensorSupply) |-> modeState == `MODE_NORMAL)
      else $error("hall supply on outside normal");
   // Cyclic sense may light a high side switch in low power only
   chk_pwm_gate: assert property (highSwitch != 2'h0 || lowSwitch != 2'h0
      |-> $past(normalish) || ($past(lowPower) && lowSwitch == 2'h0))
      else $error("switch on in wrong mode");
   chk_wdog_off: assert property ($fell(rst) && watchdogConfigPin == 2'h0
      |-> ##2 !watchdogEnable)
      else $error("watchdog on with grounded strap");
   chk_wdog_open: assert property ($fell(rst) && watchdogConfigPin == 2'h2
      |-> ##2 watchdogDefault)
      else $error("default period not chosen");
   chk_irq_hold: assert property ($fell(irqN) |-> !irqN [*8])
      else $error("interrupt dropped early");
   chk_stop_wake: assert property (modeState == `MODE_STOP && $rose(chipSelN)
      |-> ##[1:8] normalish)
      else $error("select edge did not wake");
   cover property ($rose(hallSensorSupply));
   cover property (modeState == `MODE_STOP ##1 normalish);
   cover property ($fell(irqN));
endmodule
bind sbc_mcu_control_interface sbc_mcu_control_interface_props u_props (.clk, .rst,
   .chipSelN, .serialOutEnN, .resetPinOut, .resetPinOeN, .irqN, .watchdogConfigPin,
   .watchdogEnable, .watchdogDefault, .resetCondition, .highSwitch, .lowSwitch,
   .hallSensorSupply, .modeState);

// ===== mcu_master.sv
`timescale 1ns/1ps
module mcu_master (
   // Serial link
   output reg chipSelN,
   output reg serialClk,
   output reg serialIn,
   input wire misoPin,
   // Byte read in the last frame
   output reg [7:0] rxByte
);
   // Clock idles low and stands still between frames
   initial begin
      chipSelN = 1'b1;
      serialClk = 1'b0;
      serialIn = 1'b0;
      rxByte = 8'h00;
   end
   task xfer(input [7:0] b, input integer n);
      integer k;
      begin
         chipSelN = 1'b0;
         for (k = 0; k < n; k = k + 1) begin
            serialIn = k < 8 ? b[7 - k] : 1'b0;
            #80;
            serialClk = 1'b1;
            rxByte = {rxByte[6:0], misoPin};
            #80;
            serialClk = 1'b0;
         end
         #80;
         chipSelN = 1'b1;
         // Released line must not keep the last bit
         serialIn = ~serialIn;
         #160;
      end
   endtask
endmodule

// ===== sbc_mcu_control_interface_tb.sv
`timescale 1ns/1ps
`include "sbc_mcu_ctrl_defines.vh"
module sbc_mcu_control_interface_tb;
   reg clk = 1'b0;
   reg rst = 1'b1;
   reg [1:0] watchdogConfigPin = 2'h2;
   reg faultEvent = 1'b0;
   reg resetCondition = 1'b0;
   reg pwmDriveInput = 1'b0;
   reg [3:0] wakeInput = 4'ha;
   wire chipSelN, serialClk, serialIn, serialOut, serialOutEnN, resetPinOut, resetPinOeN;
   wire irqN, watchdogEnable, watchdogDefault, hallSensorSupply;
   wire [1:0] highSwitch, lowSwitch, currentAmpGain;
   wire [2:0] analogMuxSel, modeState;
   wire [7:0] rxByte;
   // Pull-up on the reset pin
   wire resetPinIn = resetPinOeN | resetPinOut;
   wire misoPin = serialOutEnN ? 1'bz : serialOut;
   integer errors = 0;
   integer checked = 0;
   integer cycles = 0;
   integer i, s, r;
   reg [16:0] rows [0:5];
   always #2 clk = ~clk;
   sbc_mcu_control_interface #(.RST_OUT_CYC(20), .WDOG_DEF_CYC(50), .CYC_PERIOD_CYC(40))
      u_sbc_mcu_control_interface (.clk, .rst, .chipSelN, .serialClk, .serialIn, .serialOut,
      .serialOutEnN, .resetPinIn, .resetPinOut, .resetPinOeN, .irqN, .watchdogConfigPin,
      .watchdogEnable, .watchdogDefault, .faultEvent, .resetCondition, .pwmDriveInput,
      .highSwitch, .lowSwitch, .wakeInput, .analogMuxSel, .currentAmpGain,
      .hallSensorSupply, .modeState);
   mcu_master u_mcu_master (.chipSelN, .serialClk, .serialIn, .misoPin, .rxByte);
   task check(input [31:0] seen, input [31:0] exp, input [63:0] what);
      begin
         checked = checked + 1;
         if (seen !== exp) begin
            errors = errors + 1;
            $display("MISMATCH %0s expected %h seen %h", what, exp, seen);
         end
      end
   endtask
   task report_and_stop;
      begin
         $display("checked %0d errors %0d", checked, errors);
         if (errors == 0 && checked > 0)
            $display("ALL CHECKS OK");
         else
            $display("CHECKS NOT OK");
         $finish;
      end
   endtask
   task tick(input integer n);
      begin
         repeat (n) @(posedge clk);
         #1;
      end
   endtask
   task send(input [7:0] b, input integer n);
      u_mcu_master.xfer(b, n);
   endtask
   task waitUp;
      begin
         i = 0;
         while (i < 400 && modeState !== `MODE_NREQ && modeState !== `MODE_NORMAL) begin
            tick(1);
            i = i + 1;
         end
         check(i < 400, 1, "modeUp");
      end
   endtask
   task doReset;
      begin
         rst = 1'b1;
         tick(20);
         rst = 1'b0;
         waitUp;
      end
   endtask
   always @(posedge clk) begin
      cycles = cycles + 1;
      if (cycles == 20000) begin
         errors = errors + 1;
         report_and_stop;
      end
   end
   initial begin
      rows[0] = {8'h00, 9'h080};
      rows[1] = {8'h65, 9'h0a8};
      rows[2] = {8'h83, 9'h0ae};
      rows[3] = {8'ha1, 9'h0af};
      rows[4] = {8'h81, 9'h0ab};
      rows[5] = {8'h62, 9'h093};
      // Grounded strap last: no watchdog to service later
      for (s = 2; s >= 0; s = s - 1) begin
         watchdogConfigPin = s[1:0];
         doReset;
         check(watchdogEnable, s != 0, "wdogEn");
         check(watchdogDefault, s == 2, "wdogDef");
      end
      check({analogMuxSel, currentAmpGain}, {`RST_MUX, `RST_GAIN}, "rstVal");
      $display("strap test done");
      for (r = 0; r < 6; r = r + 1) begin
         send(rows[r][16:9], 8);
         check({modeState, analogMuxSel, currentAmpGain, hallSensorSupply}, rows[r][8:0],
            "row");
      end
      $display("row test done");
      send(8'he0, 8);
      check(rxByte, 8'ha8, "readback");
      send(8'h65, 7);
      send(8'h32, 9);
      check({analogMuxSel, highSwitch}, 5'h08, "badCount");
      $display("frame test done");
      send(8'h27, 8);
      send(8'h47, 8);
      pwmDriveInput = 1'b1;
      tick(6);
      check({highSwitch, lowSwitch}, 4'hf, "pwmOn");
      pwmDriveInput = 1'b0;
      tick(6);
      check({highSwitch, lowSwitch}, 4'h0, "pwmOff");
      $display("pwm test done");
      faultEvent = 1'b1;
      tick(1);
      faultEvent = 1'b0;
      tick(40);
      check(irqN, 1'b0, "irqHeld");
      send(8'he0, 8);
      check(irqN, 1'b1, "irqAck");
      $display("irq test done");
      send(8'h01, 8);
      check(modeState, `MODE_STOP, "stop");
      send(8'h00, 0);
      check(modeState === `MODE_STOP, 1'b0, "csWake");
      check(irqN, 1'b1, "csNoIrq");
      $display("select wake test done");
      doReset;
      send(8'h62, 8);
      send(8'h01, 8);
      wakeInput = 4'h8;
      tick(40);
      check(modeState, `MODE_STOP, "muxWake");
      wakeInput = 4'h9;
      tick(40);
      check(modeState === `MODE_STOP, 1'b0, "wake");
      check(irqN, 1'b0, "wakeIrq");
      $display("wake test done");
      resetCondition = 1'b1;
      tick(1);
      resetCondition = 1'b0;
      tick(2);
      check(resetPinOeN, 1'b0, "rstPull");
      waitUp;
      $display("reset pin test done");
      send(8'hc3, 8);
      send(8'he0, 8);
      send(8'h01, 8);
      tick(60);
      check(modeState, `MODE_STOP, "cycHold");
      i = 0;
      while (i < 40 && highSwitch !== 2'h2) begin
         tick(1);
         i = i + 1;
      end
      check(highSwitch, 2'h2, "cycOn");
      check(irqN, 1'b1, "cycQuiet");
      wakeInput = 4'h8;
      tick(90);
      check(modeState === `MODE_STOP, 1'b0, "cycWake");
      check(irqN, 1'b0, "cycIrq");
      $display("cyclic test done");
      report_and_stop;
   end
endmodule
